// File: verilog/lrb_pkg.sv
// constants, encodings and carriers for the led ramp and boost frequency controller
// assumes a single 10 mhz core clock and register writes from a local request port
package lrb_pkg;

	// ---------------------------------------------------------------
	// time base
	// ---------------------------------------------------------------
	localparam int LRB_CLK_NS        = 100;
	localparam int LRB_US_NS         = 1000;
	localparam int LRB_US_CYC        = (LRB_US_NS + LRB_CLK_NS - 1) / LRB_CLK_NS;
	localparam int LRB_US_CYC_UP     = LRB_US_CYC - 1;
	localparam int LRB_US_CYC_DN     = LRB_US_CYC + 1;
	localparam int LRB_MS_US         = 1000;
	localparam int LRB_RAMP_MIN_US   = 512;
	localparam int LRB_RAMP_BASE_US  = 500;
	localparam int LRB_TR_MIN_MS     = 128;
	localparam int LRB_TR_MAX_MS     = 4096;
	localparam int LRB_TR_OPTIONS    = 15;
	localparam int LRB_TR_STEP_US    = (LRB_TR_MAX_MS - LRB_TR_MIN_MS) * LRB_MS_US / (LRB_TR_OPTIONS - 1);
	localparam int LRB_PWM_BASE_MS   = 64;
	localparam int LRB_FLASH_STEP_MS = 100;
	localparam logic [10:0] LRB_CODE_MAX = 11'h7ff;

	// ---------------------------------------------------------------
	// register offsets and reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] LRB_ADDR_CUR  = 8'h03;
	localparam logic [7:0] LRB_ADDR_BC1  = 8'h04;
	localparam logic [7:0] LRB_ADDR_BC2  = 8'h05;
	localparam logic [7:0] LRB_ADDR_BRI  = 8'h07;
	localparam logic [7:0] LRB_ADDR_RAMP = 8'h09;
	localparam logic [7:0] LRB_ADDR_TRN  = 8'h0a;
	localparam logic [7:0] LRB_ADDR_FLS  = 8'h0b;
	localparam logic [7:0] LRB_ADDR_FHI  = 8'h0c;
	localparam logic [7:0] LRB_ADDR_FLO  = 8'h0d;
	localparam logic [7:0] LRB_RST_CUR   = 8'h9f;
	localparam logic [7:0] LRB_RST_BC1   = 8'h20;
	localparam logic [7:0] LRB_RST_BC2   = 8'h00;
	localparam logic [7:0] LRB_RST_BRI   = 8'h00;
	localparam logic [7:0] LRB_RST_RAMP  = 8'h44;
	localparam logic [7:0] LRB_RST_TRN   = 8'h00;
	localparam logic [7:0] LRB_RST_FLS   = 8'h58;
	localparam logic [7:0] LRB_RST_FHI   = 8'h00;
	localparam logic [7:0] LRB_RST_FLO   = 8'h00;

	// ---------------------------------------------------------------
	// field positions and encodings
	// ---------------------------------------------------------------
	localparam int LRB_FSEL_BIT = 5;
	localparam int LRB_AUTO_BIT = 7;
	localparam int LRB_IND_BIT  = 6;
	localparam logic [1:0] LRB_SHIFT_UP = 2'h1;
	localparam logic [1:0] LRB_SHIFT_DN = 2'h2;

	typedef enum logic [1:0] {lrb_f250, lrb_f500, lrb_f1m} lrb_freq_t;
	typedef enum logic [1:0] {lrb_st_off, lrb_st_up, lrb_st_on, lrb_st_down} lrb_state_t;

	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} lrb_reg_req_t;

	typedef struct packed {
		lrb_freq_t  freq;
		logic [1:0] shift;
		logic       half_duty;
		logic [6:0] drivers;
		logic       inductor_large;
	} lrb_boost_t;

endpackage

// File: verilog/lrb_ctrl.sv
// led current ramp, flash timeout and boost frequency control for a three string driver
// assumes register requests and mode/pwm inputs come from logic on mclk; only the enable pin is asynchronous
//
// Overview of operation
// - flash ends after upper nibble times 100 ms
// - flash timeout follows switching frequency shift
// - turn-on ramp time from upper ramp nibble
// - turn-off ramp time from lower ramp nibble
// - sixteen ramp times 512 us..16384 ms, default 8
// - transition ramps only after turn-on completes
// - nonzero code field gives fixed total time
// - zero code field steps one per microsecond
// - pwm changes use fixed full-scale slope
// - backlight/flash switch steps one per microsecond
// - three string enables; all zero cuts at once
// - nominal frequency 500 khz or 1 mhz
// - shift bits move nominal frequency up/down
// - driver count from slew field
// - auto frequency off by default, nominal used
// - auto mode compares msbs with two thresholds
// - low band 250 khz half duty, high 1 mhz
// - 250 khz only in auto mode
// - all ramp times follow frequency shift
// - mode field standby, backlight, flash
// - code is eight msbs plus three lsbs
// - enable pin low cuts current at once
`timescale 1ns/1ps
`default_nettype none

module lrb_ctrl
	import lrb_pkg::*;
(
	input  wire logic         mclk,
	input  wire logic         reset,
	input  wire logic         hardware_enable_pin,
	input  wire logic         soft_reset,
	input  wire logic [1:0]   operating_state_field,
	input  wire logic [2:0]   brightness_lsb,
	input  wire logic         pwm_dim_en,
	input  wire logic [10:0]  pwm_duty,
	input  wire lrb_reg_req_t reg_req,
	output logic      [7:0]   reg_rdata,
	output logic      [10:0]  led_level,
	output logic      [2:0]   string_enable,
	output var lrb_boost_t    boost,
	output logic              flash_active,
	output logic              ramp_busy
);

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// on/off ramp length; code 0 is the short special case
	function automatic logic [23:0] ramp_us(input logic [3:0] n);
		ramp_us = (n == 4'h0) ? 24'(LRB_RAMP_MIN_US) : 24'(LRB_RAMP_BASE_US) << n;
	endfunction

	// total time for a code change, evenly spread over fifteen options
	function automatic logic [23:0] tr_us(input logic [3:0] k);
		tr_us = 24'(LRB_TR_MIN_MS * LRB_MS_US) + 24'((24'(k) - 24'h1) * 24'(LRB_TR_STEP_US));
	endfunction

	// time for a full 0..100 percent pwm swing
	function automatic logic [23:0] pwm_us(input logic [2:0] m);
		pwm_us = 24'(LRB_PWM_BASE_MS * LRB_MS_US) << m;
	endfunction

	function automatic logic [27:0] to_cyc(input logic [23:0] us, input logic [3:0] c);
		to_cyc = 28'(us) * 28'(c);
	endfunction

	function automatic logic [10:0] abs_diff(input logic [10:0] a, input logic [10:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	// ---------------------------------------------------------------
	// enable pin synchroniser
	// ---------------------------------------------------------------
	logic [2:0] hw_sync_r;
	logic       hw_en_r;

	// level only moves once the second and third stage agree
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			hw_sync_r <= 3'h0;
			hw_en_r   <= 1'b0;
		end else begin
			hw_sync_r <= {hw_sync_r[1:0], hardware_enable_pin};
			if (hw_sync_r[1] == hw_sync_r[2]) begin
				hw_en_r <= hw_sync_r[2];
			end
		end
	end

	// shutdown or soft reset wipes registers and the ramp at once
	wire clr = ~hw_en_r | soft_reset;

	// ---------------------------------------------------------------
	// configuration registers
	// ---------------------------------------------------------------
	logic [7:0] cur_r, bc1_r, bc2_r, bri_r, ramp_r, trn_r, fls_r, fhi_r, flo_r;

	wire wr_cur  = reg_req.wr && (reg_req.addr == LRB_ADDR_CUR);
	wire wr_bc1  = reg_req.wr && (reg_req.addr == LRB_ADDR_BC1);
	wire wr_bc2  = reg_req.wr && (reg_req.addr == LRB_ADDR_BC2);
	wire wr_bri  = reg_req.wr && (reg_req.addr == LRB_ADDR_BRI);
	wire wr_ramp = reg_req.wr && (reg_req.addr == LRB_ADDR_RAMP);
	wire wr_trn  = reg_req.wr && (reg_req.addr == LRB_ADDR_TRN);
	wire wr_fls  = reg_req.wr && (reg_req.addr == LRB_ADDR_FLS);
	wire wr_fhi  = reg_req.wr && (reg_req.addr == LRB_ADDR_FHI);
	wire wr_flo  = reg_req.wr && (reg_req.addr == LRB_ADDR_FLO);

	// writes are dropped while the part is held in shutdown
	always_ff @(posedge mclk or posedge reset) begin
		if (reset || clr) begin
			cur_r  <= LRB_RST_CUR;
			bc1_r  <= LRB_RST_BC1;
			bc2_r  <= LRB_RST_BC2;
			bri_r  <= LRB_RST_BRI;
			ramp_r <= LRB_RST_RAMP;
			trn_r  <= LRB_RST_TRN;
			fls_r  <= LRB_RST_FLS;
			fhi_r  <= LRB_RST_FHI;
			flo_r  <= LRB_RST_FLO;
		end else begin
			if (wr_cur)  cur_r  <= reg_req.data;
			if (wr_bc1)  bc1_r  <= reg_req.data;
			if (wr_bc2)  bc2_r  <= reg_req.data;
			if (wr_bri)  bri_r  <= reg_req.data;
			if (wr_ramp) ramp_r <= reg_req.data;
			if (wr_trn)  trn_r  <= reg_req.data;
			if (wr_fls)  fls_r  <= reg_req.data;
			if (wr_fhi)  fhi_r  <= reg_req.data;
			if (wr_flo)  flo_r  <= reg_req.data;
		end
	end

	// readback of the addressed register, zero elsewhere
	wire [7:0] rd_nxt =
		(reg_req.addr == LRB_ADDR_CUR)  ? cur_r  :
		(reg_req.addr == LRB_ADDR_BC1)  ? bc1_r  :
		(reg_req.addr == LRB_ADDR_BC2)  ? bc2_r  :
		(reg_req.addr == LRB_ADDR_BRI)  ? bri_r  :
		(reg_req.addr == LRB_ADDR_RAMP) ? ramp_r :
		(reg_req.addr == LRB_ADDR_TRN)  ? trn_r  :
		(reg_req.addr == LRB_ADDR_FLS)  ? fls_r  :
		(reg_req.addr == LRB_ADDR_FHI)  ? fhi_r  :
		(reg_req.addr == LRB_ADDR_FLO)  ? flo_r  : 8'h00;

	// ---------------------------------------------------------------
	// shifted time base
	// ---------------------------------------------------------------
	// the microsecond tick stretches or shrinks with the shift, so every
	// duration derived from it tracks the switching frequency
	wire [1:0] shift = bc1_r[7:6];
	wire [3:0] us_cyc = (shift == LRB_SHIFT_UP) ? 4'(LRB_US_CYC_UP) :
		(shift == LRB_SHIFT_DN) ? 4'(LRB_US_CYC_DN) : 4'(LRB_US_CYC);

	logic [3:0] us_cnt_r;
	logic [9:0] ms_cnt_r;
	wire        us_tick = (us_cnt_r >= us_cyc - 4'h1);
	wire        ms_tick = us_tick && (ms_cnt_r == 10'(LRB_MS_US - 1));

	// free-running dividers, one-cycle enables
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			us_cnt_r <= 4'h0;
			ms_cnt_r <= 10'h000;
		end else begin
			us_cnt_r <= us_tick ? 4'h0 : us_cnt_r + 4'h1;
			if (us_tick) begin
				ms_cnt_r <= ms_tick ? 10'h000 : ms_cnt_r + 10'h001;
			end
		end
	end

	// ---------------------------------------------------------------
	// flash timeout
	// ---------------------------------------------------------------
	logic [10:0] fl_ms_r;
	logic        flash_end_r;
	wire         mode_flash = operating_state_field[1];
	wire [10:0]  fl_limit   = 11'(fls_r[7:4]) * 11'(LRB_FLASH_STEP_MS);

	// timer restarts each time flash is requested afresh; ms ticks carry the shift
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			fl_ms_r     <= 11'h000;
			flash_end_r <= 1'b0;
		end else if (clr || !mode_flash) begin
			fl_ms_r     <= 11'h000;
			flash_end_r <= 1'b0;
		end else begin
			if (ms_tick && !flash_end_r) fl_ms_r <= fl_ms_r + 11'h001;
			if (fl_ms_r >= fl_limit) flash_end_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// requested operating point
	// ---------------------------------------------------------------
	wire        want_flash = mode_flash && !flash_end_r;
	wire        want_on    = (operating_state_field == 2'h1) || want_flash;
	wire        pwm_src    = !want_flash && pwm_dim_en;
	wire [10:0] code       = {bri_r, brightness_lsb};
	wire [10:0] tgt = !want_on ? 11'h000 : want_flash ? LRB_CODE_MAX : pwm_src ? pwm_duty : code;

	// ---------------------------------------------------------------
	// ramp sequencer
	// ---------------------------------------------------------------
	lrb_state_t  st_r, st_nxt;
	logic [10:0] level_r, tgt_r, span_r;
	logic [27:0] tot_r, acc_r;
	logic        fast_r, flash_r;
	logic        start, s_fast;
	logic [10:0] s_tgt, s_span;
	logic [23:0] s_tot_us;

	wire [23:0] up_us = ramp_us(ramp_r[7:4]);
	wire [23:0] dn_us = ramp_us(ramp_r[3:0]);

	// picks a new ramp: rate is span steps per tot cycles
	always_comb begin
		start    = 1'b0;
		s_fast   = 1'b0;
		s_tgt    = tgt;
		s_span   = 11'h000;
		s_tot_us = 24'h00_0000;
		st_nxt   = st_r;
		unique case (st_r)
			lrb_st_off: begin
				if (want_on) begin
					start    = 1'b1;
					s_span   = tgt;
					s_tot_us = up_us;
					st_nxt   = lrb_st_up;
				end
			end
			lrb_st_up: begin
				if (!want_on) begin
					start    = 1'b1;
					s_span   = level_r;
					s_tot_us = dn_us;
					st_nxt   = lrb_st_down;
				end else if (level_r == tgt_r) begin
					st_nxt = lrb_st_on;
				end
			end
			lrb_st_on: begin
				if (!want_on) begin
					start    = 1'b1;
					s_span   = level_r;
					s_tot_us = dn_us;
					st_nxt   = lrb_st_down;
				end else if (want_flash != flash_r) begin
					start  = 1'b1;
					s_fast = 1'b1;
				end else if (tgt != tgt_r) begin
					start = 1'b1;
					if (pwm_src) begin
						s_span   = LRB_CODE_MAX;
						s_tot_us = pwm_us(trn_r[6:4]);
					end else if (trn_r[3:0] == 4'h0) begin
						s_fast = 1'b1;
					end else begin
						s_span   = abs_diff(tgt, level_r);
						s_tot_us = tr_us(trn_r[3:0]);
					end
				end
			end
			lrb_st_down: begin
				if (want_on) begin
					start    = 1'b1;
					s_span   = abs_diff(tgt, level_r);
					s_tot_us = up_us;
					st_nxt   = lrb_st_up;
				end else if (level_r == 11'h000) begin
					st_nxt = lrb_st_off;
				end
			end
		endcase
	end

	// fractional accumulator spreads span steps evenly; the minimum ramp is
	// longer than 2047 cycles, so at most one step is ever due per cycle
	wire [27:0] acc_sum  = acc_r + 28'(span_r);
	wire        moving   = (level_r != tgt_r);
	wire        step_due = fast_r ? us_tick : (acc_sum >= tot_r);
	wire [10:0] level_step = (tgt_r > level_r) ? level_r + 11'h001 : level_r - 11'h001;

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			st_r    <= lrb_st_off;
			level_r <= 11'h000;
			tgt_r   <= 11'h000;
			span_r  <= 11'h000;
			tot_r   <= 28'h000_0000;
			acc_r   <= 28'h000_0000;
			fast_r  <= 1'b0;
			flash_r <= 1'b0;
		end else if (clr) begin
			st_r    <= lrb_st_off;
			level_r <= 11'h000;
			tgt_r   <= 11'h000;
			acc_r   <= 28'h000_0000;
			fast_r  <= 1'b0;
			flash_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (start) begin
				tgt_r   <= s_tgt;
				span_r  <= s_span;
				tot_r   <= to_cyc(s_tot_us, us_cyc);
				fast_r  <= s_fast;
				flash_r <= want_flash;
				acc_r   <= 28'h000_0000;
			end else if (moving) begin
				if (step_due) level_r <= level_step;
				if (!fast_r) acc_r <= step_due ? acc_sum - tot_r : acc_sum;
			end
		end
	end

	// ---------------------------------------------------------------
	// boost frequency and slew selection
	// ---------------------------------------------------------------
	wire       auto_en = bc2_r[LRB_AUTO_BIT];
	wire       nom_1m  = bc1_r[LRB_FSEL_BIT];
	wire [2:0] drv_sel = bc2_r[5:3];
	// the slow band is only reachable through the auto path
	wire lrb_freq_t freq_nxt = !auto_en ? (nom_1m ? lrb_f1m : lrb_f500) :
		(bri_r < flo_r) ? lrb_f250 :
		(bri_r >= fhi_r) ? lrb_f1m : lrb_f500;
	wire [7:0]  drv_mask = (8'h02 << drv_sel) - 8'h01;

	lrb_boost_t boost_nxt;
	assign boost_nxt.freq           = freq_nxt;
	assign boost_nxt.shift          = shift;
	assign boost_nxt.half_duty      = (freq_nxt == lrb_f250);
	assign boost_nxt.drivers        = drv_mask[6:0];
	assign boost_nxt.inductor_large = bc2_r[LRB_IND_BIT];

	// ---------------------------------------------------------------
	// registered outputs
	// ---------------------------------------------------------------
	wire ch_off = (cur_r[2:0] == 3'h0);

	// all-strings-off bypasses the ramp, so the host should use standby instead
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			reg_rdata     <= 8'h00;
			led_level     <= 11'h000;
			string_enable <= 3'h0;
			boost         <= '0;
			flash_active  <= 1'b0;
			ramp_busy     <= 1'b0;
		end else begin
			reg_rdata     <= clr ? 8'h00 : rd_nxt;
			led_level     <= (clr || ch_off) ? 11'h000 : level_r;
			string_enable <= (clr || level_r == 11'h000) ? 3'h0 : cur_r[2:0];
			boost         <= boost_nxt;
			flash_active  <= !clr && flash_r && (st_r != lrb_st_off);
			ramp_busy     <= !clr && moving;
		end
	end

endmodule

`default_nettype wire

// File: tb/lrb_ctrl_assertions.sv
// port checker for the led ramp and boost frequency controller
// assumes it is bound to lrb_ctrl and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none

module lrb_ctrl_assertions
	import lrb_pkg::*;
(
	input wire logic         mclk,
	input wire logic         reset,
	input wire logic         hardware_enable_pin,
	input wire logic         soft_reset,
	input wire lrb_reg_req_t reg_req,
	input wire logic [7:0]   reg_rdata,
	input wire logic [10:0]  led_level,
	input wire logic [2:0]   string_enable,
	input wire lrb_boost_t   boost
);
	// ---------------------------------------------------------------
	// register mirror
	// ---------------------------------------------------------------
	localparam logic [39:0] RST_ALL = {LRB_RST_BC1, LRB_RST_BC2, LRB_RST_BRI, LRB_RST_FHI, LRB_RST_FLO};
	logic [7:0] bc1_r, bc2_r, bri_r, fhi_r, flo_r;
	logic [6:0] drv_exp;
	logic       wr_ok;
	logic       clr;

	// raw pin used for clears: bench never writes inside the synchroniser window
	assign clr     = soft_reset || !hardware_enable_pin;
	assign wr_ok   = reg_req.wr && !clr;
	assign drv_exp = 7'((8'h01 << (bc2_r[5:3] + 4'h1)) - 8'h01);

	// mirror of the registers that steer the boost outputs
	always_ff @(posedge mclk or posedge reset) begin
		if (reset)
			{bc1_r, bc2_r, bri_r, fhi_r, flo_r} <= RST_ALL;
		else if (clr)
			{bc1_r, bc2_r, bri_r, fhi_r, flo_r} <= RST_ALL;
		else if (wr_ok) begin
			case (reg_req.addr)
				LRB_ADDR_BC1: bc1_r <= reg_req.data;
				LRB_ADDR_BC2: bc2_r <= reg_req.data;
				LRB_ADDR_BRI: bri_r <= reg_req.data;
				LRB_ADDR_FHI: fhi_r <= reg_req.data;
				LRB_ADDR_FLO: flo_r <= reg_req.data;
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	a_nominal_freq: assert property (
		@(posedge mclk) disable iff (reset) !bc2_r[7]
		|=> boost.freq == ($past(bc1_r[5]) ? lrb_f1m : lrb_f500) && !boost.half_duty)
		else $error("nominal frequency not followed");
	a_auto_low_band: assert property (
		@(posedge mclk) disable iff (reset) bc2_r[7] && bri_r < flo_r
		|=> boost.freq == lrb_f250 && boost.half_duty)
		else $error("low band not at quarter rate");
	a_auto_mid_band: assert property (
		@(posedge mclk) disable iff (reset) bc2_r[7] && bri_r >= flo_r && bri_r < fhi_r
		|=> boost.freq == lrb_f500 && !boost.half_duty)
		else $error("middle band not at half rate");
	a_auto_high_band: assert property (
		@(posedge mclk) disable iff (reset) bc2_r[7] && bri_r >= flo_r && bri_r >= fhi_r
		|=> boost.freq == lrb_f1m)
		else $error("high band not at full rate");
	a_driver_count: assert property (
		@(posedge mclk) disable iff (reset) bc2_r[5:3] != 3'h7 |=> boost.drivers == $past(drv_exp))
		else $error("driver count wrong");
	a_shift_bits: assert property (
		@(posedge mclk) disable iff (reset)
		1'b1 |=> boost.shift == $past(bc1_r[7:6]) && boost.inductor_large == $past(bc2_r[6]))
		else $error("shift or inductor field wrong");
	a_all_off_cut: assert property (
		@(posedge mclk) disable iff (reset) wr_ok && reg_req.addr == LRB_ADDR_CUR && reg_req.data[2:0] == 3'h0
		|=> ##[1:3] led_level == 11'h000 && string_enable == 3'h0)
		else $error("strings off did not cut at once");
	a_enable_cut: assert property (
		@(posedge mclk) disable iff (reset) !hardware_enable_pin [*7] |-> led_level == 11'h000)
		else $error("enable pin low did not cut level");
	a_threshold_read: assert property (
		@(posedge mclk) disable iff (reset) !reg_req.wr && !clr && reg_req.addr == LRB_ADDR_FLO
		|=> reg_rdata == $past(flo_r))
		else $error("low threshold readback wrong");
endmodule

bind lrb_ctrl lrb_ctrl_assertions u_chk (.mclk(mclk), .reset(reset), .hardware_enable_pin(hardware_enable_pin),
	.soft_reset(soft_reset), .reg_req(reg_req), .reg_rdata(reg_rdata), .led_level(led_level),
	.string_enable(string_enable), .boost(boost));

`default_nettype wire

// File: tb/lrb_host_model.sv
// host model that programs the controller registers
// assumes the register port of lrb_ctrl on the same mclk
`timescale 1ns/1ps
`default_nettype none

module lrb_host_model
	import lrb_pkg::*;
#(
	parameter bit IND_LARGE = 1'b1 // board fits the large inductor
)
(
	input  wire logic       mclk,
	input  wire logic [7:0] reg_rdata,
	output var lrb_reg_req_t reg_req
);
	// idle on an unmapped offset so a stray read returns zero
	initial reg_req = '{wr: 1'b0, addr: 8'h0e, data: 8'h00};

	// one write: request held one edge, data inverted after so it never lingers
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_req <= '{wr: 1'b1, addr: a, data: d};
		@(posedge mclk);
		reg_req.wr   <= 1'b0;
		reg_req.data <= ~d;
	endtask

	// readback answers one cycle after the offset is presented
	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_req.addr <= a;
		@(posedge mclk);
		#1 d = reg_rdata;
	endtask

	// inductor range bit always follows the fitted part
	function automatic logic [7:0] bc2_val(input logic auto_on, input logic [2:0] slew);
		return {auto_on, IND_LARGE, slew, 3'h0};
	endfunction
endmodule

`default_nettype wire

// File: tb/lrb_ctrl_tb.sv
// self-checking bench for the led ramp and boost frequency controller
// assumes lrb_ctrl with its bound checker and the host model on the register port
`timescale 1ns/1ps
`default_nettype none

module lrb_ctrl_tb;
	import lrb_pkg::*;
	localparam logic [7:0] ADRS [9] = '{LRB_ADDR_CUR, LRB_ADDR_BC1, LRB_ADDR_BC2, LRB_ADDR_BRI,
		LRB_ADDR_RAMP, LRB_ADDR_TRN, LRB_ADDR_FLS, LRB_ADDR_FHI, LRB_ADDR_FLO};
	localparam logic [7:0] RSTS [9] = '{LRB_RST_CUR, LRB_RST_BC1, LRB_RST_BC2, LRB_RST_BRI,
		LRB_RST_RAMP, LRB_RST_TRN, LRB_RST_FLS, LRB_RST_FHI, LRB_RST_FLO};
	logic         mclk, reset, hardware_enable_pin, soft_reset, pwm_dim_en, flash_active, ramp_busy;
	logic [1:0]   operating_state_field;
	logic [2:0]   brightness_lsb, string_enable;
	logic [10:0]  pwm_duty, led_level;
	logic [7:0]   reg_rdata, rd;
	lrb_reg_req_t reg_req;
	lrb_boost_t   boost;
	int           err_count, checks_done;
	int           regm [int];

	lrb_ctrl uut (.mclk(mclk), .reset(reset), .hardware_enable_pin(hardware_enable_pin),
		.soft_reset(soft_reset), .operating_state_field(operating_state_field),
		.brightness_lsb(brightness_lsb), .pwm_dim_en(pwm_dim_en), .pwm_duty(pwm_duty), .reg_req(reg_req),
		.reg_rdata(reg_rdata), .led_level(led_level), .string_enable(string_enable), .boost(boost),
		.flash_active(flash_active), .ramp_busy(ramp_busy));
	lrb_host_model u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_req(reg_req));

	// ---------------------------------------------------------------
	// reporting and comparison
	// ---------------------------------------------------------------
	task automatic print_verdict();
		if (err_count == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic report(input logic [31:0] got, input logic [31:0] exp);
		err_count++;
		$display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) report(32'(got), 32'(exp));
	endtask
	task automatic chk_lvl(input logic [10:0] got, input logic [10:0] exp);
		checks_done++;
		if (got !== exp) report(32'(got), 32'(exp));
	endtask
	task automatic chk_boost(input lrb_boost_t got, input lrb_boost_t exp);
		checks_done++;
		if (got !== exp) report(32'(got), 32'(exp));
	endtask
	// ramp length may drift a little from rounding of the step spacing
	task automatic chk_time(input int got, input int exp);
		checks_done++;
		if (got > exp + exp / 16 + 20 || got < exp - exp / 16) report(got, exp);
	endtask

	// ---------------------------------------------------------------
	// reference model
	// ---------------------------------------------------------------
	task automatic defaults();
		for (int i = 0; i < 9; i++)
			regm[ADRS[i]] = RSTS[i];
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		u_host.wreg(a, d);
		if (regm.exists(a))
			regm[a] = d;
	endtask
	task automatic check_regs();
		for (int i = 0; i < 9; i++) begin
			u_host.rreg(ADRS[i], rd);
			chk_reg(rd, 8'(regm[ADRS[i]]));
		end
		u_host.rreg(8'h0e, rd);
		chk_reg(rd, 8'h00);
	endtask
	function automatic lrb_boost_t exp_boost();
		lrb_boost_t b;
		int c1, c2, br;
		c1 = regm[LRB_ADDR_BC1];
		c2 = regm[LRB_ADDR_BC2];
		br = regm[LRB_ADDR_BRI];
		b.shift = 2'(c1 >> 6);
		b.inductor_large = c2[6];
		b.drivers = 7'((1 << (((c2 >> 3) & 7) + 1)) - 1);
		if (!c2[7])
			b.freq = c1[5] ? lrb_f1m : lrb_f500;
		else if (br < regm[LRB_ADDR_FLO])
			b.freq = lrb_f250;
		else if (br >= regm[LRB_ADDR_FHI])
			b.freq = lrb_f1m;
		else
			b.freq = lrb_f500;
		b.half_duty = (b.freq == lrb_f250);
		return b;
	endfunction
	// set the mode and count cycles until the ramp settles
	task automatic ramp(input logic [1:0] mode, input int exp_cyc);
		int n;
		n = 3;
		@(posedge mclk);
		operating_state_field <= mode;
		repeat (3) @(negedge mclk);
		while (ramp_busy !== 1'b0 && n < 200000) begin
			@(negedge mclk);
			n++;
		end
		chk_time(n, exp_cyc);
		@(negedge mclk);
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog and sequence
	// ---------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// about 72k cycles of traffic; 120k cycles means a hang
	initial begin
		repeat (120000) @(posedge mclk);
		err_count++;
		print_verdict();
	end
	initial begin
		reset = 1'b1;
		hardware_enable_pin = 1'b1;
		soft_reset = 1'b0;
		operating_state_field = 2'b00;
		brightness_lsb = 3'h7;
		pwm_dim_en = 1'b0;
		pwm_duty = 11'h000;
		void'($urandom(93195));
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		defaults();
		repeat (6) @(posedge mclk);
		check_regs();
		chk_boost(boost, exp_boost());
		// random boost settings, every fourth with brightness on the low threshold
		for (int i = 0; i < 24; i++) begin
			wr(LRB_ADDR_BC1, 8'($urandom_range(0, 255)));
			wr(LRB_ADDR_BC2, u_host.bc2_val(1'($urandom_range(0, 1)), 3'($urandom_range(0, 6))));
			wr(LRB_ADDR_BRI, 8'($urandom_range(0, 255)));
			wr(LRB_ADDR_FLO, (i % 4 == 0) ? 8'(regm[LRB_ADDR_BRI]) : 8'($urandom_range(0, 255)));
			wr(LRB_ADDR_FHI, 8'($urandom_range(0, 255)));
			pwm_duty <= 11'($urandom_range(0, 2047));
			repeat (2) @(negedge mclk);
			chk_boost(boost, exp_boost());
		end
		check_regs();
		// ramps at nominal rate: up 512 us, down 1000 us
		wr(LRB_ADDR_BC1, LRB_RST_BC1);
		wr(LRB_ADDR_BC2, u_host.bc2_val(1'b0, 3'h6));
		wr(LRB_ADDR_RAMP, 8'h01);
		wr(LRB_ADDR_FLS, 8'h18);
		wr(LRB_ADDR_BRI, 8'hff);
		ramp(2'b01, 5120);
		chk_lvl(led_level, 11'h7ff);
		wr(LRB_ADDR_BRI, 8'h70);
		ramp(2'b01, 11440);
		chk_lvl(led_level, 11'h387);
		ramp(2'b10, 11440);
		chk_reg(8'(flash_active), 8'h01);
		ramp(2'b00, 10000);
		chk_lvl(led_level, 11'h000);
		// zero timeout: flash ends by itself while the field still asks for it
		wr(LRB_ADDR_FLS, 8'h08);
		operating_state_field <= 2'b10;
		repeat (12000) @(negedge mclk);
		chk_lvl(led_level, 11'h000);
		// shifted up: every microsecond is nine cycles; turn on first so the
		// turn-off ramp has a level to bring down
		wr(LRB_ADDR_BC1, 8'h60);
		ramp(2'b01, 4608);
		// pwm swing of 16 codes on a 64 ms full-scale slope, shifted: 16*576000/2047
		@(posedge mclk);
		pwm_duty   <= 11'h397;
		pwm_dim_en <= 1'b1;
		ramp(2'b01, 4502);
		chk_lvl(led_level, 11'h397);
		wr(LRB_ADDR_CUR, 8'h98);
		repeat (4) @(negedge mclk);
		chk_lvl(led_level, 11'h000);
		chk_reg(8'(string_enable), 8'h00);
		wr(LRB_ADDR_CUR, LRB_RST_CUR);
		pwm_dim_en <= 1'b0;
		ramp(2'b00, 9000);
		chk_lvl(led_level, 11'h000);
		// soft clear puts every register back
		@(posedge mclk);
		soft_reset <= 1'b1;
		operating_state_field <= 2'b00;
		@(posedge mclk);
		soft_reset <= 1'b0;
		defaults();
		check_regs();
		wr(LRB_ADDR_BRI, 8'hff);
		operating_state_field <= 2'b01;
		repeat (3000) @(posedge mclk);
		hardware_enable_pin <= 1'b0;
		repeat (8) @(negedge mclk);
		chk_lvl(led_level, 11'h000);
		print_verdict();
	end
endmodule

`default_nettype wire
